// file: verilog/urt_defs.vh
// Purpose: constants of the rx timeout and dma trigger block
// Assumes: 32-bit axi4-lite register bus, byte addresses
// Notes:   included by the top design file of the block, not by the counter
`ifndef URT_DEFS_VH
`define URT_DEFS_VH

// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define URT_A_RXHOLD   8'h00
`define URT_A_IDENT    8'h04
`define URT_A_LSTAT    8'h08
`define URT_A_MSTAT    8'h0c
`define URT_A_EFC2     8'h10
`define URT_A_TMO_LO   8'h14
`define URT_A_TMO_HI   8'h18
`define URT_A_TRIG     8'h1c
`define URT_A_ISTAT    8'h20
`define URT_A_IMASK    8'h24

// ---------------------------------------------------------------
// fields and values
// ---------------------------------------------------------------
`define URT_EFC2_PERIODIC 6
`define URT_IDENT_TMO     8'h0c
`define URT_IDENT_NONE    8'h01
`define URT_IS_TMO        0
`define URT_IS_RXDMA      1
`define URT_IS_TXDMA      2
`define URT_IS_W          3
`define URT_TMO_RST       16'hffff
`define URT_TRIG_RST      16'h0101
`define URT_LVL_W         7
`define URT_RESP_OK       2'b00
`define URT_RESP_ERR      2'b10
`define URT_TMO_LO_RST    8'hff
`define URT_TMO_HI_RST    8'hff
`define URT_CH_W          2
`define URT_CHL_W         (`URT_CH_W*`URT_LVL_W)
`define URT_CH_TX         0
`define URT_CH_RX         1
`define URT_TRIG_STRIDE   8
`define URT_LVL_ZERO      7'h00
`define URT_LVL_ONE       7'h01

`endif

// file: verilog/urt_tmo_cnt.v
// Purpose: rx character timeout down-counter
// Assumes: one count per clock cycle while armed and running
// Notes:   expire is a one-cycle pulse from a flip-flop
`timescale 1ns/1ps
module urt_tmo_cnt (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // control
  input  wire        reload,
  input  wire [15:0] load_val,
  input  wire        run,
  input  wire        periodic,
  // event
  output reg         expire_r
);

  reg  [15:0] cnt_r;
  reg         armed_r;
  wire        last;

  assign last = (cnt_r <= 16'h0001);

  // ---------------------------------------------------------------
  // count down while idle with data, fire once the count is down to one
  // ---------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r    <= 16'h0000;
      armed_r  <= 1'b0;
      expire_r <= 1'b0;
    end else begin
      expire_r <= 1'b0;
      if (reload) begin
        cnt_r   <= load_val;
        armed_r <= 1'b1;
      end else if (armed_r && run) begin
        if (last) begin
          expire_r <= 1'b1;
          if (periodic) begin
            cnt_r <= load_val;
          end else begin
            armed_r <= 1'b0;
          end
        end else begin
          cnt_r <= cnt_r - 16'h0001;
        end
      end
    end
  end

endmodule

// file: verilog/urt_rx_timeout_dma.v
// Purpose: rx timeout interrupt and fifo dma trigger, axi4-lite slave
// Assumes: fifo levels and rx data come from logic on aclk
// Notes:   rx_line is a pin and is synchronised before use
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "urt_defs.vh"
module urt_rx_timeout_dma (
  // clock and reset
  input  wire                  aclk,
  input  wire                  aresetn,
  // axi4-lite write address
  input  wire [7:0]            s_axi_awaddr,
  input  wire                  s_axi_awvalid,
  output reg                   s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]           s_axi_wdata,
  input  wire [3:0]            s_axi_wstrb,
  input  wire                  s_axi_wvalid,
  output reg                   s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]            s_axi_bresp,
  output reg                   s_axi_bvalid,
  input  wire                  s_axi_bready,
  // axi4-lite read address
  input  wire [7:0]            s_axi_araddr,
  input  wire                  s_axi_arvalid,
  output reg                   s_axi_arready,
  // axi4-lite read data
  output reg  [31:0]           s_axi_rdata,
  output reg  [1:0]            s_axi_rresp,
  output reg                   s_axi_rvalid,
  input  wire                  s_axi_rready,
  // receiver side
  input  wire                  rx_line,
  input  wire                  rx_char_stb,
  input  wire [7:0]            rx_data,
  input  wire [`URT_LVL_W-1:0] rx_level,
  output reg                   rx_pop_r,
  // transmitter side
  input  wire [`URT_LVL_W-1:0] tx_space,
  // line and modem status
  input  wire [7:0]            line_stat,
  input  wire [7:0]            modem_stat,
  // dma and interrupt
  output reg                   rx_dma_req_r,
  output reg                   tx_dma_req_r,
  output reg                   irq_r
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // programmable registers
  reg  [7:0]            efc2_r;
  reg  [7:0]            tmo_lo_r;
  reg  [7:0]            tmo_hi_r;
  reg  [15:0]           trig_r;
  // interrupt and timeout state
  reg  [`URT_IS_W-1:0]  istat_r;
  reg  [`URT_IS_W-1:0]  imask_r;
  reg                   tmo_pend_r;
  // synchroniser and bus capture
  reg                   rx_s1_r;
  reg                   rx_s2_r;
  reg                   aw_ok_r;
  reg                   w_ok_r;
  reg  [7:0]            aw_addr_r;
  reg  [31:0]           w_data_r;
  reg  [3:0]            w_strb_r;
  // next values
  reg  [31:0]           rd_nxt;
  reg                   rd_err_nxt;
  reg                   wr_err_nxt;

  wire                  tmo_expire;
  wire                  rx_has_data;
  wire                  periodic;
  wire                  wr_go;
  wire                  rd_go;
  wire                  ident_rd;
  wire                  hold_rd;
  wire                  rearm;
  wire                  wr_lane0;
  wire [7:0]            ident_code;
  // dma slices, tx at index 0, rx at index 1
  wire [`URT_CHL_W-1:0] ch_levels;
  wire [`URT_CH_W-1:0]  dma_cur;
  wire [`URT_CH_W-1:0]  dma_nxt;
  wire [`URT_CH_W-1:0]  dma_rise;
  wire [`URT_IS_W-1:0]  ev;
  wire [`URT_IS_W-1:0]  w1c;
  wire [`URT_IS_W-1:0]  istat_nxt;
  genvar                ch;

  // ---------------------------------------------------------------
  // mode, bus decode and read side effects
  // ---------------------------------------------------------------
  assign rx_has_data = (rx_level != {`URT_LVL_W{1'b0}});
  assign periodic    = efc2_r[`URT_EFC2_PERIODIC];
  // a write commits only once its response slot is free
  assign wr_go       = aw_ok_r && w_ok_r && !s_axi_bvalid;
  assign wr_lane0    = wr_go && w_strb_r[0];
  assign rd_go       = s_axi_arvalid && s_axi_arready;
  // only the ident read touches the timeout; the holding read decodes the pop strobe
  assign ident_rd    = rd_go && (s_axi_araddr == `URT_A_IDENT);
  assign hold_rd     = rd_go && (s_axi_araddr == `URT_A_RXHOLD);
  assign ident_code  = tmo_pend_r ? `URT_IDENT_TMO : `URT_IDENT_NONE;

  // ---------------------------------------------------------------
  // timeout re-arm
  // ---------------------------------------------------------------
  // a cleared timeout with data still queued starts a fresh period;
  // periodic mode needs none, its counter never stops
  assign rearm = ident_rd && tmo_pend_r && rx_has_data && !periodic;

  // ---------------------------------------------------------------
  // rx line synchroniser
  // ---------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      // idle level, so release shows no false activity
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
    end else begin
      rx_s1_r <= rx_line;
      rx_s2_r <= rx_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // timeout counter
  // ---------------------------------------------------------------
  urt_tmo_cnt u_tmo (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .reload   (rx_char_stb | rearm),
    .load_val ({tmo_hi_r, tmo_lo_r}),
    .run      (rx_s2_r && rx_has_data),
    .periodic (periodic),
    .expire_r (tmo_expire)
  );

  // ---------------------------------------------------------------
  // timeout pending flag, set wins over the ident read clear
  // ---------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      tmo_pend_r <= 1'b0;
    end else if (tmo_expire) begin
      tmo_pend_r <= 1'b1;
    end else if (ident_rd) begin
      tmo_pend_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // dma requests by fifo level, one slice per direction
  // ---------------------------------------------------------------
  assign ch_levels = {rx_level, tx_space};
  assign dma_cur   = {rx_dma_req_r, tx_dma_req_r};

  generate
    for (ch = 0; ch < `URT_CH_W; ch = ch + 1) begin : g_dma
      wire [`URT_LVL_W-1:0] lvl;
      wire [`URT_LVL_W-1:0] lvl_field;
      wire [`URT_LVL_W-1:0] lvl_trig;
      assign lvl       = ch_levels[ch*`URT_LVL_W +: `URT_LVL_W];
      assign lvl_field = trig_r[ch*`URT_TRIG_STRIDE +: `URT_LVL_W];
      // zero trigger level behaves as level one
      assign lvl_trig  = (lvl_field == `URT_LVL_ZERO) ? `URT_LVL_ONE : lvl_field;
      // plain level compare, so no trigger value gives a stray request
      assign dma_nxt[ch]  = (lvl >= lvl_trig);
      assign dma_rise[ch] = dma_nxt[ch] && !dma_cur[ch];
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_dma_req_r <= 1'b0;
      tx_dma_req_r <= 1'b0;
    end else begin
      rx_dma_req_r <= dma_nxt[`URT_CH_RX];
      tx_dma_req_r <= dma_nxt[`URT_CH_TX];
    end
  end

  // ---------------------------------------------------------------
  // interrupt status, mask and output
  // ---------------------------------------------------------------
  // dma events mark the rising edge of a request
  assign ev[`URT_IS_TMO]   = tmo_expire;
  assign ev[`URT_IS_RXDMA] = dma_rise[`URT_CH_RX];
  assign ev[`URT_IS_TXDMA] = dma_rise[`URT_CH_TX];
  // write one to clear, byte lane 0 only
  assign w1c = (wr_lane0 && aw_addr_r == `URT_A_ISTAT) ?
               w_data_r[`URT_IS_W-1:0] : {`URT_IS_W{1'b0}};
  // an event in the clearing cycle wins
  assign istat_nxt = (istat_r & ~w1c) | ev;

  always @(posedge aclk) begin
    if (!aresetn) begin
      istat_r <= {`URT_IS_W{1'b0}};
      irq_r   <= 1'b0;
    end else begin
      istat_r <= istat_nxt;
      irq_r   <= |(istat_nxt & imask_r);
    end
  end

  // ---------------------------------------------------------------
  // axi write channels, address and data in either order
  // ---------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_r       <= 1'b0;
      w_ok_r        <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h00000000;
      w_strb_r      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `URT_RESP_OK;
    end else begin
      // ready pulses every other cycle while the channel is free
      s_axi_awready <= !aw_ok_r && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_ok_r && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_r       <= 1'b1;
        aw_addr_r     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_r       <= 1'b1;
        w_data_r     <= s_axi_wdata;
        w_strb_r     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_ok_r      <= 1'b0;
        w_ok_r       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_err_nxt ? `URT_RESP_ERR : `URT_RESP_OK;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  always @* begin
    // read-only and unmapped offsets answer with an error
    case (aw_addr_r)
      `URT_A_EFC2,
      `URT_A_TMO_LO,
      `URT_A_TMO_HI,
      `URT_A_TRIG,
      `URT_A_ISTAT,
      `URT_A_IMASK: wr_err_nxt = 1'b0;
      default:      wr_err_nxt = 1'b1;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      efc2_r   <= 8'h00;
      tmo_lo_r <= `URT_TMO_LO_RST;
      tmo_hi_r <= `URT_TMO_HI_RST;
      trig_r   <= `URT_TRIG_RST;
      imask_r  <= {`URT_IS_W{1'b0}};
    end else if (wr_go) begin
      case (aw_addr_r)
        `URT_A_EFC2: begin
          if (w_strb_r[0]) efc2_r <= w_data_r[7:0];
        end
        `URT_A_TMO_LO: begin
          if (w_strb_r[0]) tmo_lo_r <= w_data_r[7:0];
        end
        `URT_A_TMO_HI: begin
          if (w_strb_r[0]) tmo_hi_r <= w_data_r[7:0];
        end
        `URT_A_TRIG: begin
          // rx trigger byte rides on lane 1
          if (w_strb_r[0]) trig_r[7:0] <= w_data_r[7:0];
          if (w_strb_r[1]) trig_r[15:8] <= w_data_r[15:8];
        end
        `URT_A_IMASK: begin
          if (w_strb_r[0]) imask_r <= w_data_r[`URT_IS_W-1:0];
        end
        default: begin
          imask_r <= imask_r;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read decode; status reads carry no timeout side effect
  // ---------------------------------------------------------------
  always @* begin
    rd_nxt     = 32'h00000000;
    rd_err_nxt = 1'b0;
    // unmapped offsets read zero with an error
    case (s_axi_araddr)
      `URT_A_RXHOLD: rd_nxt[7:0] = rx_data;
      `URT_A_IDENT:  rd_nxt[7:0] = ident_code;
      `URT_A_LSTAT:  rd_nxt[7:0] = line_stat;
      `URT_A_MSTAT:  rd_nxt[7:0] = modem_stat;
      `URT_A_EFC2:   rd_nxt[7:0] = efc2_r;
      `URT_A_TMO_LO: rd_nxt[7:0] = tmo_lo_r;
      `URT_A_TMO_HI: rd_nxt[7:0] = tmo_hi_r;
      `URT_A_TRIG:   rd_nxt[15:0] = trig_r;
      `URT_A_ISTAT:  rd_nxt[`URT_IS_W-1:0] = istat_r;
      `URT_A_IMASK:  rd_nxt[`URT_IS_W-1:0] = imask_r;
      default:       rd_err_nxt = 1'b1;
    endcase
  end

  // ---------------------------------------------------------------
  // axi read channels
  // ---------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `URT_RESP_OK;
      rx_pop_r      <= 1'b0;
    end else begin
      // ready stays low after each take until the read response is accepted, so one request is seen once
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      // no pop on an empty fifo, so a stray read cannot underflow it
      rx_pop_r      <= hold_rd && rx_has_data;
      if (rd_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_nxt;
        s_axi_rresp   <= rd_err_nxt ? `URT_RESP_ERR : `URT_RESP_OK;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// file: tb/urt_fifo_mdl.sv
// Purpose: far-side rx fifo model feeding the receiver inputs
// Assumes: one character lands per push pulse
// Notes:   head data tracks the fill level
`timescale 1ns/1ps
module urt_fifo_mdl (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // control
  input  wire logic       push,
  input  wire logic       rx_pop_r,
  // receiver side
  output logic            rx_line,
  output logic            rx_char_stb,
  output logic [7:0]      rx_data,
  output logic [6:0]      rx_level
);
  assign rx_data = {1'b0, rx_level} | 8'h40;
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_line <= 1'b1;
      rx_char_stb <= 1'b0;
      rx_level <= 7'h00;
    end else begin
      // line busy for the cycle a character lands
      rx_line <= !push;
      rx_char_stb <= push;
      if (push && !rx_pop_r)
        rx_level <= rx_level + 7'h01;
      else if (rx_pop_r && !push && rx_level != 7'h00)
        rx_level <= rx_level - 7'h01;
    end
  end
endmodule

// file: tb/urt_rx_timeout_dma_properties.sv
// Purpose: port-level checks of the rx timeout block
// Assumes: one aclk domain, sync active-low reset
// Notes:   bound into every instance
`timescale 1ns/1ps
`include "urt_defs.vh"
module urt_props_chk (
  // clock and reset
  input wire logic                  aclk,
  input wire logic                  aresetn,
  // bus
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wready,
  input wire logic                  s_axi_bvalid,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_bready,
  input wire logic [7:0]            s_axi_araddr,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic                  s_axi_rvalid,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic                  s_axi_rready,
  // fifo and dma
  input wire logic [`URT_LVL_W-1:0] rx_level,
  input wire logic [`URT_LVL_W-1:0] tx_space,
  input wire logic                  rx_pop_r,
  input wire logic                  rx_dma_req_r,
  input wire logic                  tx_dma_req_r
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence ar_take_s;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence hold_rd_s;
    s_axi_araddr == `URT_A_RXHOLD && rx_level != 0;
  endsequence
  rd_answer_a: assert property (ar_take_s |=> s_axi_rvalid)
    else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  pop_after_a: assert property (ar_take_s ##0 hold_rd_s |-> ##[1:2] rx_pop_r)
    else $error("holding read did not pop");
  pop_pulse_a: assert property (rx_pop_r |=> !rx_pop_r)
    else $error("pop longer than one cycle");
  rx_req_lvl_a: assert property (rx_dma_req_r |-> $past(rx_level) != 0)
    else $error("rx request with empty fifo");
  tx_req_lvl_a: assert property (tx_dma_req_r |-> $past(tx_space) != 0)
    else $error("tx request with no space");
endmodule
bind urt_rx_timeout_dma urt_props_chk urt_props_chk_i (.aclk, .aresetn, .s_axi_awready,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bresp, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .s_axi_rready, .rx_level, .tx_space,
  .rx_pop_r, .rx_dma_req_r, .tx_dma_req_r);

// file: tb/tb_top.sv
// Purpose: self-checking bench of the rx timeout block
// Assumes: 25 MHz aclk, reset held 16 cycles
// Notes:   timeout reload kept at 64 cycles
`timescale 1ns/1ps
`include "urt_defs.vh"
module tb_top;
  logic        aclk = 0, aresetn = 0, push = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [6:0]  tx_space = 0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         rx_line, rx_char_stb, rx_pop_r, rx_dma_req_r, tx_dma_req_r, irq_r;
  wire  [7:0]  rx_data;
  wire  [6:0]  rx_level;
  int          err_total = 0, num_checks = 0;
  always #20 aclk = ~aclk;
  urt_rx_timeout_dma urt_rx_timeout_dma_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_line, .rx_char_stb, .rx_data,
    .rx_level, .rx_pop_r, .tx_space, .line_stat(8'h61), .modem_stat(8'h9b), .rx_dma_req_r,
    .tx_dma_req_r, .irq_r);
  urt_fifo_mdl urt_fifo_mdl_i (.aclk, .aresetn, .push, .rx_pop_r, .rx_line, .rx_char_stb,
    .rx_data, .rx_level);
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 0);
    logic pa, pw, pb;
    int n;
    @(posedge aclk);
    pa = 1;
    pw = 1;
    pb = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    for (n = 0; n < 60 && pb; n++) begin
      @(negedge aclk);
      pa = pa & !s_axi_awready;
      pw = pw & !s_axi_wready;
      pb = !s_axi_bvalid;
      if (!pb) chk("bresp", s_axi_bresp, er);
      @(posedge aclk);
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {pa, pw, pb};
    end
    if (pb) chk("bdone", 0, 1);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 0);
    logic pa, pr;
    int n;
    @(posedge aclk);
    pa = 1;
    pr = 1;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    for (n = 0; n < 60 && pr; n++) begin
      @(negedge aclk);
      pa = pa & !s_axi_arready;
      pr = !s_axi_rvalid;
      if (!pr) chk($sformatf("rdata %h", a), s_axi_rdata, e);
      if (!pr) chk("rresp", s_axi_rresp, er);
      @(posedge aclk);
      {s_axi_arvalid, s_axi_rready} <= {pa, pr};
    end
    if (pr) chk("rdone", 0, 1);
  endtask
  task automatic waitn(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic put;
    @(posedge aclk);
    push <= 1;
    @(posedge aclk);
    push <= 0;
  endtask
  task automatic t_regs;
    rdc(`URT_A_TMO_LO, 32'hff);
    rdc(`URT_A_TMO_HI, 32'hff);
    rdc(`URT_A_TRIG, 32'h0101);
    rdc(8'h30, 0, `URT_RESP_ERR);
    wr(8'h30, 1, `URT_RESP_ERR);
    wr(`URT_A_TMO_LO, 32'h40);
    wr(`URT_A_TMO_HI, 0);
    rdc(`URT_A_TMO_LO, 32'h40);
    rdc(`URT_A_TMO_HI, 0);
    $display("test regs done");
  endtask
  task automatic t_tmo;
    wr(`URT_A_IMASK, 1);
    put();
    put();
    waitn(50);
    chk("irq early", irq_r, 0);
    for (int n = 0; n < 100 && irq_r !== 1; n++) @(negedge aclk);
    chk("irq", irq_r, 1);
    rdc(`URT_A_IDENT, `URT_IDENT_TMO);
    rdc(`URT_A_IDENT, `URT_IDENT_NONE);
    rdc(`URT_A_LSTAT, 8'h61);
    rdc(`URT_A_MSTAT, 8'h9b);
    rdc(`URT_A_RXHOLD, 8'h42);
    rdc(`URT_A_IDENT, `URT_IDENT_NONE);
    waitn(100);
    rdc(`URT_A_IDENT, `URT_IDENT_TMO);
    $display("test timeout done");
  endtask
  task automatic t_modes;
    for (int m = 0; m < 2; m++) begin
      wr(`URT_A_EFC2, m << 6);
      rdc(`URT_A_EFC2, m << 6);
      wr(`URT_A_ISTAT, 1);
      waitn(150);
      wr(`URT_A_ISTAT, 1);
      waitn(2);
      if (m == 0) chk("irq cleared", irq_r, 0);
      waitn(150);
      chk("irq mode", irq_r, m);
      // one-shot has stopped; clearing the pending timeout re-arms it
      if (m == 0) rdc(`URT_A_IDENT, `URT_IDENT_TMO);
    end
    $display("test modes done");
  endtask
  task automatic t_dma;
    int lv[6] = '{1, 2, 4, 8, 16, 32};
    foreach (lv[i]) begin
      wr(`URT_A_TRIG, (lv[i] << 8) | lv[i]);
      tx_space <= lv[i] - 1;
      waitn(3);
      chk("txreq low", tx_dma_req_r, 0);
      chk("rxreq", rx_dma_req_r, lv[i] == 1);
      @(posedge aclk);
      tx_space <= lv[i];
      waitn(3);
      chk("txreq high", tx_dma_req_r, 1);
    end
    wr(`URT_A_IMASK, 4);
    waitn(2);
    chk("irq masked in", irq_r, 1);
    wr(`URT_A_ISTAT, 4);
    waitn(2);
    chk("irq w1c", irq_r, 0);
    $display("test dma done");
  endtask
  task automatic t_pop;
    wr(`URT_A_IMASK, 1);
    rdc(`URT_A_RXHOLD, 8'h41);
    wr(`URT_A_ISTAT, 1);
    waitn(150);
    chk("irq empty", irq_r, 0);
    $display("test empty done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    t_regs();
    t_tmo();
    t_modes();
    t_dma();
    t_pop();
    complete_run();
  end
  initial begin
    #2000000;
    err_total++;
    complete_run();
  end
endmodule
